// file: core/fast_parallel_config_port.sv
// device side of the fast parallel configuration load port
// assumes the host drives request, config clock and data bus;
// the status pin is open drain, resolved outside this module
// Behaviour
// [R1] byte mode: ratio 1 plain or encrypted, 2 whenever compressed
// [R2] word mode: ratio 1 plain, 2 encrypted, 4 whenever compressed
// [R3] host clocks config clock at ratio times the data rate
// [R4] host gives ratio minus one extra clock edges after last word
// [R5] done output falls within 600 ns of request falling
// [R6] status line falls within 600 ns of request falling
// [R7] host holds request low at least 2 us
// [R8] status stays low 268 to 1506 us unless delayed externally
// [R9] status released within 1506 us of request rising
// [R10] monitoring host waits 2 us after status high before clocking
// [R11] non-monitoring host waits 1506 us after request high
// [R12] data bus captured on config clock rising edge
// [R13] external low hold on status postpones loading until release
// [R14] longer request low pulse stretches the status low period
// [R15] host holds each word stable for ratio clock cycles
module fast_parallel_config_port
    import fast_parallel_pkg::*;
#(
    parameter logic [CNT_W-1:0] STATUS_LOW_MIN_CYC = STATUS_LOW_MIN_CYC_DEF,
    parameter logic [WORDS_W-1:0] IMAGE_WORDS = IMAGE_WORDS_DEF
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic configRequestN,
    input wire logic configClock,
    input wire logic [DATA_W-1:0] configData,
    input wire logic wideMode,
    input wire logic encryptOn,
    input wire logic compressOn,
    input wire logic deviceReadyIn,
    output logic deviceReadyOut,
    output logic deviceReadyOeN,
    output logic loadComplete,
    output logic [DATA_W-1:0] wordData,
    output logic wordValid
);
    localparam int REQ_LOW_CYC = REQ_TO_LOW_MAX_CYC;

    typedef struct packed {
        logic reqMeta;
        logic reqSync;
        logic clkMeta;
        logic clkSync;
        logic clkPrev;
        logic rdyMeta;
        logic rdySync;
        logic [DATA_W-1:0] dataMeta;
        logic [DATA_W-1:0] dataSync;
        logic [2:0] modeMeta;
        logic [2:0] modeSync;
        load_state_e state;
        logic [CNT_W-1:0] lowCnt;
        logic [2:0] ratio;
        logic [1:0] phase;
        logic [WORDS_W-1:0] words;
        logic wide;
        logic drive;
        logic done;
        logic [DATA_W-1:0] word;
        logic valid;
    } port_s;

    port_s s_r;
    port_s s_nxt;
    logic clkRise;
    logic [DATA_W-1:0] capture;

    assign clkRise = s_r.clkSync & ~s_r.clkPrev; // [R12]
    assign capture = s_r.wide ? s_r.dataSync
                              : {{BYTE_W{1'b0}}, s_r.dataSync[BYTE_W-1:0]};

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.valid = 1'b0;
        // two flops on every pin before any logic reads it
        s_nxt.reqMeta = configRequestN;
        s_nxt.reqSync = s_r.reqMeta;
        s_nxt.clkMeta = configClock;
        s_nxt.clkSync = s_r.clkMeta;
        s_nxt.clkPrev = s_r.clkSync;
        s_nxt.rdyMeta = deviceReadyIn;
        s_nxt.rdySync = s_r.rdyMeta;
        s_nxt.dataMeta = configData;
        s_nxt.dataSync = s_r.dataMeta;
        s_nxt.modeMeta = {wideMode, encryptOn, compressOn};
        s_nxt.modeSync = s_r.modeMeta;
        if (!s_r.reqSync && s_r.state != HOLD_LOW)
        begin
            // sync delay is a few cycles, far inside the 600 ns limit
            s_nxt.state = HOLD_LOW; // [R5] [R6]
            s_nxt.lowCnt = '0;
            s_nxt.drive = 1'b1;
            s_nxt.done = 1'b0;
        end
        else
        begin
            unique case (s_r.state)
                HOLD_LOW:
                begin
                    s_nxt.drive = 1'b1;
                    s_nxt.done = 1'b0;
                    s_nxt.phase = '0;
                    s_nxt.words = '0;
                    if (s_r.lowCnt != STATUS_LOW_MAX_CYC)
                        s_nxt.lowCnt = s_r.lowCnt + 1'b1; // [R8]
                    // counts from the request fall, so a long pulse
                    // simply stretches the low time
                    if (s_r.reqSync && s_r.lowCnt >= STATUS_LOW_MIN_CYC)
                    begin
                        s_nxt.state = WAIT_RELEASE; // [R9] [R14]
                        s_nxt.drive = 1'b0;
                    end
                end
                WAIT_RELEASE:
                begin
                    // modes locked here; changing them mid-load is ignored
                    s_nxt.ratio = ratioOf(s_r.modeSync[2], s_r.modeSync[1],
                                          s_r.modeSync[0]); // [R1] [R2]
                    s_nxt.wide = s_r.modeSync[2];
                    if (s_r.rdySync)
                        s_nxt.state = LOADING; // [R13]
                end
                LOADING:
                begin
                    if (clkRise)
                    begin
                        if (s_r.phase == 2'h0)
                        begin
                            s_nxt.word = capture; // [R12]
                            s_nxt.valid = 1'b1;
                            s_nxt.words = s_r.words + 1'b1;
                            if (s_r.words + 1'b1 == IMAGE_WORDS)
                                s_nxt.state = (s_r.ratio == RATIO_ONE)
                                    ? COMPLETE : FLUSHING;
                        end
                        s_nxt.phase = (s_r.phase == 2'(s_r.ratio - 1'b1))
                            ? 2'h0 : s_r.phase + 1'b1; // [R3] [R15]
                    end
                end
                FLUSHING:
                begin
                    // trailing edges finish decrypt and decompress
                    if (clkRise)
                    begin
                        s_nxt.phase = s_r.phase + 1'b1;
                        if (s_r.phase == 2'(s_r.ratio - 1'b1))
                            s_nxt.state = COMPLETE; // [R4]
                    end
                end
                COMPLETE:
                    s_nxt.done = 1'b1;
                default:
                    s_nxt.state = HOLD_LOW;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.state <= HOLD_LOW;
            s_r.drive <= 1'b1;
            s_r.ratio <= RATIO_ONE;
        end
        else
            s_r <= s_nxt;
    end

    assign deviceReadyOut = 1'b0;
    assign deviceReadyOeN = ~s_r.drive;
    assign loadComplete = s_r.done;
    assign wordData = s_r.word;
    assign wordValid = s_r.valid;

    a_done_drop: assert property (@(posedge clock) disable iff (rst) // [R5]
        $fell(configRequestN) |-> ##[1:REQ_LOW_CYC] !loadComplete)
        else $error("done not low after request fall");
    a_status_drop: assert property (@(posedge clock) disable iff (rst) // [R6]
        $fell(configRequestN) |-> ##[1:REQ_LOW_CYC] !deviceReadyOeN)
        else $error("status not low after request fall");
    a_status_min: assert property (@(posedge clock) disable iff (rst) // [R8]
        $rose(deviceReadyOeN) |-> $past(s_r.lowCnt) >= STATUS_LOW_MIN_CYC)
        else $error("status released too early");
    // a long request pulse leaves the counter past the minimum
    a_late_release: assert property (@(posedge clock) disable iff (rst) // [R9]
        (s_r.state == HOLD_LOW && s_r.reqSync
            && s_r.lowCnt >= STATUS_LOW_MIN_CYC) |=> deviceReadyOeN)
        else $error("status release late after request rise");
    a_low_stretch: assert property (@(posedge clock) disable iff (rst) // [R14]
        !s_r.reqSync |=> !deviceReadyOeN)
        else $error("status released while request low");
    a_outside_hold: assert property (@(posedge clock) disable iff (rst) // [R13]
        (s_r.state == WAIT_RELEASE && !s_r.rdySync && s_r.reqSync)
            |=> s_r.state == WAIT_RELEASE)
        else $error("load started while status held low");
    a_capture_edge: assert property (@(posedge clock) disable iff (rst) // [R12]
        wordValid |-> $past(clkRise) && wordData == $past(capture))
        else $error("word not taken on clock rise");
    a_byte_ratio: assert property (@(posedge clock) disable iff (rst) // [R1]
        (s_r.state == LOADING && !s_r.wide)
            |-> s_r.ratio == ($past(s_r.modeSync[0], 2) ? 3'h2 : 3'h1)
            || $past(s_r.state) == LOADING)
        else $error("byte mode ratio wrong");
    a_word_ratio: assert property (@(posedge clock) disable iff (rst) // [R2]
        (s_r.state == LOADING && s_r.wide && $past(s_r.state) == WAIT_RELEASE)
            |-> s_r.ratio == ($past(s_r.modeSync[0]) ? RATIO_FOUR
                : $past(s_r.modeSync[1]) ? RATIO_TWO : RATIO_ONE))
        else $error("word mode ratio wrong");
    a_flush_done: assert property (@(posedge clock) disable iff (rst) // [R4]
        (s_r.state == FLUSHING && clkRise && s_r.phase == 2'(s_r.ratio - 1'b1))
            |=> ##1 loadComplete)
        else $error("done not raised after trailing edges");

    c_load_start: cover property (@(posedge clock) disable iff (rst)
        s_r.state == WAIT_RELEASE ##1 s_r.state == LOADING);
    c_flush: cover property (@(posedge clock) disable iff (rst)
        s_r.state == FLUSHING ##1 s_r.state == COMPLETE);
    c_reconfig: cover property (@(posedge clock) disable iff (rst)
        loadComplete ##1 !loadComplete);
endmodule // fast_parallel_config_port

// file: include/fast_parallel_pkg.sv
// constants and types for the fast parallel configuration port
// assumes a 200 MHz system clock; all pins arrive asynchronously
package fast_parallel_pkg;
    localparam int CLOCK_MHZ = 200;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int REQ_TO_LOW_MAX_NS = 600;
    localparam int REQ_TO_LOW_MAX_CYC = REQ_TO_LOW_MAX_NS / CLOCK_PERIOD_NS;
    localparam int STATUS_LOW_MIN_US = 268;
    localparam int STATUS_LOW_MAX_US = 1506;
    localparam int CNT_W = 19;
    localparam logic [CNT_W-1:0] STATUS_LOW_MIN_CYC_DEF =
        CNT_W'(STATUS_LOW_MIN_US * CLOCK_MHZ);
    localparam logic [CNT_W-1:0] STATUS_LOW_MAX_CYC =
        CNT_W'(STATUS_LOW_MAX_US * CLOCK_MHZ);
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int WORDS_W = 24;
    localparam logic [WORDS_W-1:0] IMAGE_WORDS_DEF = 24'h00_0400;
    localparam logic [2:0] RATIO_ONE = 3'h1;
    localparam logic [2:0] RATIO_TWO = 3'h2;
    localparam logic [2:0] RATIO_FOUR = 3'h4;

    typedef enum logic [2:0] {
        HOLD_LOW,
        WAIT_RELEASE,
        LOADING,
        FLUSHING,
        COMPLETE
    } load_state_e;

    // clock-to-data ratio from bus width and features
    function automatic logic [2:0] ratioOf(
        input logic wide,
        input logic encrypt,
        input logic compress
    );
        if (compress)
            return wide ? RATIO_FOUR : RATIO_TWO;
        else if (encrypt && wide)
            return RATIO_TWO;
        else
            return RATIO_ONE;
    endfunction
endpackage

// file: verif/config_host.sv
// host model: drives request, config clock and data bus
// assumes an open-drain status wire with pull-up resolved by the bench
module config_host
    import fast_parallel_pkg::*;
(
    input wire logic statusWire,
    output logic configRequestN,
    output logic configClock,
    output logic [DATA_W-1:0] configData
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 24;
    initial
    begin
        configRequestN = 1'b1;
        configClock = 1'b0;
        configData = 16'h0000;
    end
    // the bench times the low pulse, at least 2 us
    task automatic setRequest(input logic level);
        configRequestN <= level;
    endtask
    // monitoring host: release, then the settle gap before clocking
    task automatic waitReady(output bit ok);
        int n;
        n = 0;
        while (statusWire !== 1'b1 && n < 100000)
        begin
            #1;
            n++;
        end
        ok = n < 100000;
        #2000;
    endtask
    // host that ignores status: fixed wait after request high
    task automatic waitBlind(input int ns);
        #(ns);
    endtask
    // clock idles low outside frames; bus shows inverse when released
    task automatic runEdges(input int first, input int last, input int r);
        for (int e = first; e < last; e++)
        begin
            configData = 16'h3C5A + 16'(e / r) * 16'h0F11;
            #HALF_NS;
            configClock = 1'b1;
            #HALF_NS;
            configClock = 1'b0;
        end
        if (last > first)
            configData = ~configData;
    endtask
endmodule // config_host

// file: verif/tb.sv
// bench top: resets the port, stretches a request, loads all modes
// assumes config_host as far side and a pull-up on the status wire
module tb
    import fast_parallel_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CNT_W-1:0] MIN_LOW = 19'h0_0258;
    localparam logic [WORDS_W-1:0] WORDS = 24'h00_0004;
    // scaled blind wait: the shortened status low time is a few us
    localparam int BLIND_NS = 8000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wideMode = 1'b0, encryptOn = 1'b0, compressOn = 1'b0;
    logic extHold = 1'b0;
    logic configRequestN, configClock, deviceReadyIn;
    logic [DATA_W-1:0] configData, wordData;
    logic deviceReadyOut, deviceReadyOeN, loadComplete, wordValid;
    int nMismatch = 0;
    int totalChecks = 0;
    int nSeen = 0;
    int cyc = 0;

    always #2.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    assign deviceReadyIn = ((!deviceReadyOeN && !deviceReadyOut) || extHold)
        ? 1'b0 : 1'b1;

    fast_parallel_config_port #(.STATUS_LOW_MIN_CYC(MIN_LOW),
        .IMAGE_WORDS(WORDS)) dut (.clock(clock), .rst(rst),
        .configRequestN(configRequestN), .configClock(configClock),
        .configData(configData), .wideMode(wideMode),
        .encryptOn(encryptOn), .compressOn(compressOn),
        .deviceReadyIn(deviceReadyIn), .deviceReadyOut(deviceReadyOut),
        .deviceReadyOeN(deviceReadyOeN), .loadComplete(loadComplete),
        .wordData(wordData), .wordValid(wordValid));
    config_host host (.statusWire(deviceReadyIn),
        .configRequestN(configRequestN), .configClock(configClock),
        .configData(configData));

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (nMismatch == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic abort(input string what);
        check(what, 32'h0000_0000, 32'h0000_0001);
        tally_and_finish();
    endtask
    // byte mode leaves the upper byte zero
    function automatic logic [15:0] expWord(input int i);
        logic [15:0] w;
        w = 16'h3C5A + 16'(i) * 16'h0F11;
        return wideMode ? w : {8'h00, w[7:0]};
    endfunction
    always @(posedge clock)
    begin
        if (wordValid === 1'b1)
        begin
            check("wordData", wordData, expWord(nSeen));
            nSeen <= nSeen + 1;
        end
    end
    task automatic waitRelease(input int bound);
        int n;
        n = 0;
        while (deviceReadyOeN !== 1'b1 && n < bound)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= bound) abort("statusRelease");
    endtask
    task automatic restart(input int lowCyc);
        int n;
        int t0;
        int lo;
        @(posedge clock);
        host.setRequest(1'b0);
        n = 0;
        while ((deviceReadyOeN !== 1'b0 || loadComplete !== 1'b0) && n < 121)
        begin
            @(posedge clock);
            n++;
        end
        if (n > 120) abort("fallDelay");
        t0 = cyc;
        repeat (lowCyc) @(posedge clock);
        check("heldLow", deviceReadyOeN, 1'b0);
        check("pullLevel", deviceReadyOut, 1'b0);
        host.setRequest(1'b1);
        waitRelease(2000);
        lo = lowCyc > int'(MIN_LOW) ? lowCyc : int'(MIN_LOW);
        check("lowMin", cyc - t0 >= lo - 3, 1'b1);
        check("lowMax", cyc - t0 <= lo + 10, 1'b1);
    endtask
    // awkward case: clock the last word's tail edges separately
    task automatic load(input logic [2:0] mode, input logic hold);
        bit ok;
        int r;
        r = 1;
        if (mode[0])
            r = mode[2] ? 4 : 2;
        else if (mode[2] && mode[1])
            r = 2;
        @(posedge clock);
        {wideMode, encryptOn, compressOn} <= mode;
        extHold <= hold;
        nSeen = 0;
        restart(420);
        if (hold)
        begin
            host.runEdges(0, 8, 1);
            repeat (6) @(posedge clock);
            check("heldCaptures", nSeen, 0);
            extHold <= 1'b0;
        end
        if (mode == 3'h4)
            host.waitBlind(BLIND_NS);
        else
        begin
            host.waitReady(ok);
            if (!ok) abort("hostReady");
        end
        host.runEdges(0, 3 * r + 1, r);
        repeat (20) @(posedge clock);
        if (r > 1) check("earlyDone", loadComplete, 1'b0);
        if (r > 1) host.runEdges(3 * r + 1, 4 * r, r);
        repeat (8) @(posedge clock);
        check("done", loadComplete, 1'b1);
        check("wordCount", nSeen, 4);
    endtask

    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        #1;
        check("resetPins", {deviceReadyOeN, loadComplete}, 2'h0);
        waitRelease(700);
        restart(1000);
        for (int m = 0; m < 8; m++)
            load(3'(m), m == 0);
        tally_and_finish();
    end
endmodule // tb
